// ---- irqc_consts.svh ----
// register offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef IRQC_CONSTS_SVH
`define IRQC_CONSTS_SVH

// register bus geometry
`define IRQC_ADDR_W 8
`define IRQC_DATA_W 8

// register offsets
`define IRQC_OFF_CONTROL 8'h00
`define IRQC_OFF_PERIPH_EN0 8'h01
`define IRQC_OFF_FLAG0 8'h02
`define IRQC_OFF_PERIPH_EN 8'h03
`define IRQC_OFF_PERIPH_FLAG 8'h04
`define IRQC_OFF_STATE 8'h05
// shadow bank 31 window: eight words from this base
`define IRQC_OFF_SHADOW_BASE 8'hF8
`define IRQC_SHADOW_BANK_MASK 8'hF8

// interrupt_control field positions
`define IRQC_BIT_GIE 7
`define IRQC_BIT_PERIPHERAL_IRQ_ENABLE 6
`define IRQC_BIT_EDGE 0
// first enable / flag register field positions
`define IRQC_BIT_EXT 0

// reset values
`define IRQC_RST_GIE 1'b0
`define IRQC_RST_PERIPHERAL_IRQ_ENABLE 1'b0
`define IRQC_RST_EDGE 1'b1

// status bits kept out of the shadow copy (timeout and powerdown)
`define IRQC_STATUS_SAVE_MASK 8'hE7

// interrupt vector
`define IRQC_PC_W 15
`define IRQC_VECTOR 15'h0004

// clocks per instruction cycle at 50 MHz (one Q1 pulse each)
`define IRQC_Q_DIV 4

// shadow word count
`define IRQC_SHADOW_WORDS 8

`endif

// ---- irqc_pkg.sv ----
// types shared by the interrupt controller files
package irqc_pkg;

	// entry sequencer states, one-hot
	typedef enum logic [3:0] {
		IRQC_RUN = 4'b0001, // normal execution, sampling at Q1
		IRQC_FINISH = 4'b0010, // current instruction completes
		IRQC_NOP1 = 4'b0100, // first forced no-operation
		IRQC_NOP2 = 4'b1000 // second forced no-operation
	} irqc_state_e;

	// core context saved on entry and restored on return
	typedef struct packed {
		logic [7:0] pc_upper_latch; // pc upper latch
		logic [7:0] fsr1h; // indirect pointer 1 high
		logic [7:0] fsr1l; // indirect pointer 1 low
		logic [7:0] fsr0h; // indirect pointer 0 high
		logic [7:0] fsr0l; // indirect pointer 0 low
		logic [7:0] bank_select; // bank select
		logic [7:0] status; // core status
		logic [7:0] wreg; // working register
	} irqc_ctx_s;

	// register bus request
	typedef struct packed {
		logic wr; // write strobe
		logic rd; // read strobe
		logic [7:0] addr; // register address
		logic [7:0] wdata; // write data
	} irqc_bus_s;

	// commands from the controller to the core pipeline
	typedef struct packed {
		logic flush; // discard the prefetched instruction
		logic force_nop; // execute a no-operation this cycle
		logic push; // push o_push_pc onto the stack
		logic pop; // pop the return address
		logic load_vector; // load the PC with the vector
		logic restore; // take restored context
	} irqc_core_cmd_s;

endpackage : irqc_pkg

// ---- irqc_edge_det.sv ----
// edge detector with selectable polarity for the external interrupt pin
`timescale 1ns/10ps
module irqc_edge_det
	import irqc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_pin, // external pin level, synchronous
	input wire logic i_rising, // 1 rising edge, 0 falling edge
	output logic o_edge // one-cycle pulse on a selected edge
);

	logic prev_q; // pin level last cycle
	logic primed_q; // prev_q holds a real sample
	logic rise_w;
	logic fall_w;

	// edge terms from current and previous level
	assign rise_w = i_pin & ~prev_q;
	assign fall_w = ~i_pin & prev_q;
	assign o_edge = primed_q & (i_rising ? rise_w : fall_w);

	// remember the pin; no edge is reported for the first sample after reset
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_q <= 1'b0;
			primed_q <= 1'b0;
		end else begin
			prev_q <= i_pin;
			primed_q <= 1'b1;
		end
	end

endmodule : irqc_edge_det

// ---- irqc_shadow_mem.sv ----
// shadow register store: parallel save and word access with registered read
`timescale 1ns/10ps
module irqc_shadow_mem
	import irqc_pkg::*;
#(
	parameter int WORDS = 8,
	parameter int WIDTH = 8
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_save, // load every word at once
	input wire logic [WORDS*WIDTH-1:0] i_save_data, // words to save, word 0 lowest
	input wire logic i_wr, // single word write
	input wire logic i_rd, // single word read
	input wire logic [$clog2(WORDS)-1:0] i_addr, // word index
	input wire logic [WIDTH-1:0] i_wdata, // write data
	output logic [WIDTH-1:0] o_rdata, // read data, one cycle after i_rd
	output logic [WORDS*WIDTH-1:0] o_all // whole store for restore
);

	localparam int AW = $clog2(WORDS); // word index width
	logic [WIDTH-1:0] mem_q [WORDS]; // the shadow words

	// refuse shapes the index cannot address
	if (WORDS < 2 || (WORDS & (WORDS - 1)) != 0) begin : g_chk
		$error("irqc_shadow_mem: WORDS must be a power of two, at least 2");
	end

	// per word: a hardware save wins over a software write in the same cycle
	for (genvar gi = 0; gi < WORDS; gi++) begin : g_word
		always_ff @(posedge i_clock or negedge i_rst_n) begin
			if (!i_rst_n) begin
				mem_q[gi] <= '0;
			end else if (i_save) begin
				mem_q[gi] <= i_save_data[gi*WIDTH +: WIDTH];
			end else if (i_wr && i_addr == AW'(gi)) begin
				mem_q[gi] <= i_wdata;
			end
		end
		assign o_all[gi*WIDTH +: WIDTH] = mem_q[gi];
	end

	// registered read port
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			o_rdata <= mem_q[i_addr];
		end
	end

endmodule : irqc_shadow_mem

// ---- irqc_top.sv ----
// interrupt controller: enables, flags, wake, entry sequencing and context save/restore
`timescale 1ns/10ps
`include "irqc_consts.svh"
module irqc_top
	import irqc_pkg::*;
#(
	parameter int N_PERIPH = 8, // peripheral event sources
	parameter int Q_DIV = `IRQC_Q_DIV // clocks per instruction cycle
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// event sources
	input wire logic i_ext_pin,
	input wire logic [N_PERIPH-1:0] i_periph_event,
	// core side
	input wire logic i_core_sleeping, // core is in Sleep
	input wire logic i_return_from_handler, // return instruction executes (Q1 cycle)
	input wire logic [`IRQC_PC_W-1:0] i_core_pc, // PC of instruction now executing
	input wire irqc_ctx_s i_core_ctx, // live core context
	output logic o_q1, // instruction cycle start pulse
	output logic o_wake, // bring the core out of Sleep
	output irqc_core_cmd_s o_core_cmd, // pipeline commands, valid with o_q1
	output logic [`IRQC_PC_W-1:0] o_push_pc, // return address to push
	output logic [`IRQC_PC_W-1:0] o_vector_pc, // address to load
	output irqc_ctx_s o_restore_ctx, // context to restore
	output logic o_irq_pending // an enabled request is present and the global enable is set
);

	localparam int QW = $clog2(Q_DIV);

	// refuse parameter values the logic cannot serve
	if (N_PERIPH < 1 || N_PERIPH > `IRQC_DATA_W) begin : g_chk_n
		$error("irqc_top: N_PERIPH must be 1..8");
	end
	if (Q_DIV < 2) begin : g_chk_q
		$error("irqc_top: Q_DIV must be at least 2");
	end

	// decode of a register offset, used by reads and writes
	function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
		is_off = (a == off);
	endfunction : is_off

	// bus bundled as one request
	irqc_bus_s bus_w;
	assign bus_w = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr, wdata: i_reg_wdata};

	// registers
	logic gie_q; // global_irq_enable
	logic peripheral_irq_enable_q; // peripheral_irq_enable
	logic edge_q; // ext_edge_select
	logic ext_en_q; // ext_irq_enable
	logic ext_flag_q; // ext_irq_flag
	logic [N_PERIPH-1:0] pen_q; // peripheral individual enables
	logic [N_PERIPH-1:0] pflag_q; // peripheral flags
	logic [QW-1:0] qcnt_q; // instruction cycle divider
	irqc_state_e state_q; // entry sequencer
	irqc_state_e state_d;
	logic [`IRQC_PC_W-1:0] ret_pc_q; // return address held for the push
	logic [7:0] rdata_q; // registered read data of plain registers
	logic rd_shadow_q; // last read went to the shadow bank

	// decoded strobes
	logic wr_ctl_w;
	logic wr_en0_w;
	logic wr_flag0_w;
	logic wr_pen_w;
	logic wr_pflag_w;
	logic in_shadow_w;
	assign wr_ctl_w = bus_w.wr & is_off(bus_w.addr, `IRQC_OFF_CONTROL);
	assign wr_en0_w = bus_w.wr & is_off(bus_w.addr, `IRQC_OFF_PERIPH_EN0);
	assign wr_flag0_w = bus_w.wr & is_off(bus_w.addr, `IRQC_OFF_FLAG0);
	assign wr_pen_w = bus_w.wr & is_off(bus_w.addr, `IRQC_OFF_PERIPH_EN);
	assign wr_pflag_w = bus_w.wr & is_off(bus_w.addr, `IRQC_OFF_PERIPH_FLAG);
	assign in_shadow_w = (bus_w.addr & `IRQC_SHADOW_BANK_MASK) == `IRQC_OFF_SHADOW_BASE;

	// instruction cycle divider: o_q1 is the one-cycle Q1 enable
	// the divider restarts at zero on reset, so the first cycle after release is a Q1
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			qcnt_q <= '0;
		end else if (qcnt_q == QW'(Q_DIV - 1)) begin
			qcnt_q <= '0;
		end else begin
			qcnt_q <= qcnt_q + 1'b1;
		end
	end
	assign o_q1 = (qcnt_q == '0);

	// external pin edge
	logic ext_edge_w;
	irqc_edge_det u_edge (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_pin(i_ext_pin),
		.i_rising(edge_q),
		.o_edge(ext_edge_w)
	);

	// request terms
	logic ext_req_w; // enabled pin request
	logic [N_PERIPH-1:0] pact_w; // flag and individual enable
	logic periph_req_w; // enabled peripheral request
	logic any_req_w; // any request that may interrupt
	assign ext_req_w = ext_flag_q & ext_en_q;
	assign pact_w = pflag_q & pen_q;
	assign periph_req_w = (|pact_w) & peripheral_irq_enable_q;
	assign any_req_w = ext_req_w | periph_req_w;
	assign o_irq_pending = any_req_w & gie_q;

	// wake ignores the global enable so a disabled core just resumes
	// a core woken with the global enable clear carries on after its sleep
	// instruction; the flag stays set and is taken once software sets the enable
	assign o_wake = i_core_sleeping & any_req_w;

	// entry and exit events
	// sampling waits until the core is awake, so the instruction after the sleep
	// always runs first and the vector follows only after the two no-operations
	logic take_w; // sample at Q1 finds a request
	logic enter_w; // entry actions happen this cycle
	logic exit_w; // return actions happen this cycle
	assign take_w = o_q1 & (state_q == IRQC_RUN) & o_irq_pending & ~i_core_sleeping;
	assign enter_w = o_q1 & (state_q == IRQC_FINISH);
	assign exit_w = o_q1 & (state_q == IRQC_RUN) & i_return_from_handler;

	// sequencer next state: finish, two no-operations, then the vector runs
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			IRQC_RUN: begin
				if (take_w) begin
					state_d = IRQC_FINISH;
				end
			end
			IRQC_FINISH: begin
				if (o_q1) begin
					state_d = IRQC_NOP1;
				end
			end
			IRQC_NOP1: begin
				if (o_q1) begin
					state_d = IRQC_NOP2;
				end
			end
			IRQC_NOP2: begin
				if (o_q1) begin
					state_d = IRQC_RUN;
				end
			end
			default: begin
				state_d = IRQC_RUN; // illegal code recovers
			end
		endcase
	end

	// sequencer state and the PC to return to
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= IRQC_RUN;
			ret_pc_q <= '0;
		end else begin
			state_q <= state_d;
			if (take_w) begin
				ret_pc_q <= i_core_pc + 1'b1;
			end
		end
	end

	// pipeline commands, each a pulse on a Q1 cycle
	assign o_core_cmd.flush = enter_w;
	assign o_core_cmd.force_nop = o_q1 & (state_q == IRQC_FINISH || state_q == IRQC_NOP1);
	assign o_core_cmd.push = enter_w;
	assign o_core_cmd.load_vector = enter_w;
	assign o_core_cmd.pop = exit_w;
	assign o_core_cmd.restore = exit_w;
	assign o_push_pc = ret_pc_q;
	assign o_vector_pc = `IRQC_VECTOR;

	// global enable: hardware clear on entry and set on return win over software
	// a same-cycle software write loses, so entry never leaves the enable set
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gie_q <= `IRQC_RST_GIE;
		end else if (enter_w) begin
			gie_q <= 1'b0;
		end else if (exit_w) begin
			gie_q <= 1'b1;
		end else if (wr_ctl_w) begin
			gie_q <= bus_w.wdata[`IRQC_BIT_GIE];
		end
	end

	// software-only control bits; bits 5..1 have no storage
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			peripheral_irq_enable_q <= `IRQC_RST_PERIPHERAL_IRQ_ENABLE;
			edge_q <= `IRQC_RST_EDGE;
			ext_en_q <= 1'b0;
			pen_q <= '0;
		end else begin
			if (wr_ctl_w) begin
				peripheral_irq_enable_q <= bus_w.wdata[`IRQC_BIT_PERIPHERAL_IRQ_ENABLE];
				edge_q <= bus_w.wdata[`IRQC_BIT_EDGE];
			end
			if (wr_en0_w) begin
				ext_en_q <= bus_w.wdata[`IRQC_BIT_EXT];
			end
			if (wr_pen_w) begin
				pen_q <= bus_w.wdata[N_PERIPH-1:0];
			end
		end
	end

	// flags: an event in the cycle of a software write still sets the flag
	// peripheral events are ORed over the written value, so a write cannot lose one
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ext_flag_q <= 1'b0;
			pflag_q <= '0;
		end else begin
			if (ext_edge_w) begin
				ext_flag_q <= 1'b1;
			end else if (wr_flag0_w) begin
				ext_flag_q <= bus_w.wdata[`IRQC_BIT_EXT];
			end
			if (wr_pflag_w) begin
				pflag_q <= bus_w.wdata[N_PERIPH-1:0] | i_periph_event;
			end else begin
				pflag_q <= pflag_q | i_periph_event;
			end
		end
	end

	// context to save: timeout and powerdown kept out of the status copy
	irqc_ctx_s save_ctx_w;
	irqc_ctx_s shadow_ctx_w;
	logic [7:0] shadow_rdata_w;
	always_comb begin
		save_ctx_w = i_core_ctx;
		save_ctx_w.status = i_core_ctx.status & `IRQC_STATUS_SAVE_MASK;
	end

	// shadow registers, reachable by software in bank 31
	// save and software write may meet in one cycle; the store lets the save win
	irqc_shadow_mem #(
		.WORDS(`IRQC_SHADOW_WORDS),
		.WIDTH(8)
	) u_shadow (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_save(enter_w),
		.i_save_data(save_ctx_w),
		.i_wr(bus_w.wr & in_shadow_w),
		.i_rd(bus_w.rd & in_shadow_w),
		.i_addr(bus_w.addr[2:0]),
		.i_wdata(bus_w.wdata),
		.o_rdata(shadow_rdata_w),
		.o_all(shadow_ctx_w)
	);
	assign o_restore_ctx = shadow_ctx_w;

	// read mux of the plain registers; unmapped offsets read zero
	logic [7:0] ctl_rd_w;
	logic [7:0] state_rd_w;
	logic [7:0] rd_mux_w;
	assign ctl_rd_w = {gie_q, peripheral_irq_enable_q, 5'h00, edge_q};
	assign state_rd_w = {3'h0, o_irq_pending, state_q};
	always_comb begin
		rd_mux_w = 8'h00;
		if (is_off(bus_w.addr, `IRQC_OFF_CONTROL)) begin
			rd_mux_w = ctl_rd_w;
		end else if (is_off(bus_w.addr, `IRQC_OFF_PERIPH_EN0)) begin
			rd_mux_w = {7'h00, ext_en_q};
		end else if (is_off(bus_w.addr, `IRQC_OFF_FLAG0)) begin
			rd_mux_w = {7'h00, ext_flag_q};
		end else if (is_off(bus_w.addr, `IRQC_OFF_PERIPH_EN)) begin
			rd_mux_w = 8'(pen_q);
		end else if (is_off(bus_w.addr, `IRQC_OFF_PERIPH_FLAG)) begin
			rd_mux_w = 8'(pflag_q);
		end else if (is_off(bus_w.addr, `IRQC_OFF_STATE)) begin
			rd_mux_w = state_rd_w;
		end
	end

	// registered read data, held one cycle after the read strobe
	// shadow reads come from the store's own register and are picked after it
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= 8'h00;
			rd_shadow_q <= 1'b0;
		end else if (bus_w.rd) begin
			rdata_q <= rd_mux_w;
			rd_shadow_q <= in_shadow_w;
		end
	end
	assign o_reg_rdata = rd_shadow_q ? shadow_rdata_w : rdata_q;

endmodule : irqc_top

// ---- irqc_top_chk.sv ----
// port assertions for the interrupt controller
`timescale 1ns/10ps
module irqc_top_chk
	import irqc_pkg::*;
#(
	parameter int N_PERIPH = 8,
	parameter int Q_DIV = 4
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_core_sleeping,
	input wire logic [14:0] i_core_pc,
	input wire irqc_ctx_s i_core_ctx,
	input wire logic o_q1,
	input wire logic o_wake,
	input wire irqc_core_cmd_s o_core_cmd,
	input wire logic [14:0] o_push_pc,
	input wire logic [14:0] o_vector_pc,
	input wire irqc_ctx_s o_restore_ctx,
	input wire logic o_irq_pending
);
	// context bits kept by the shadow copy: status loses timeout and powerdown
	localparam logic [63:0] SAVE_MASK = 64'hFFFF_FFFF_FFFF_E7FF;
	default clocking dc @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	a_vector_fixed: assert property (o_vector_pc == 15'h0004)
		else $error("vector address wrong");
	a_q1_period: assert property (o_q1 && $past(i_rst_n) |=> !o_q1 [*3] ##1 o_q1)
		else $error("instruction cycle pulse spacing wrong");
	a_cmd_on_q1: assert property (|o_core_cmd |-> o_q1)
		else $error("pipeline command away from cycle start");
	a_entry_steps: assert property (o_core_cmd.load_vector |->
		o_core_cmd.flush && o_core_cmd.push && o_core_cmd.force_nop
		##4 (o_core_cmd.force_nop && !o_core_cmd.push) ##4 !o_core_cmd.force_nop)
		else $error("entry sequence wrong");
	a_push_addr: assert property (o_core_cmd.push |->
		o_push_pc == $past(i_core_pc, 4) + 15'h0001)
		else $error("pushed return address wrong");
	a_ctx_saved: assert property (o_core_cmd.load_vector |=>
		o_restore_ctx == ($past(i_core_ctx) & SAVE_MASK))
		else $error("shadow copy wrong");
	a_taken_cause: assert property (o_core_cmd.flush |-> $past(o_irq_pending, 4))
		else $error("entry without pending request");
	a_wake_sleep: assert property (o_wake |-> i_core_sleeping)
		else $error("wake while awake");
	a_pop_restore: assert property (o_core_cmd.pop |-> o_core_cmd.restore)
		else $error("pop without restore");
	a_ctrl_zero: assert property (i_reg_rd && i_reg_addr == 8'h00 |=>
		o_reg_rdata[5:1] == 5'h00)
		else $error("unused control bits not zero");
	// main scenarios
	c_entry: cover property (o_core_cmd.load_vector);
	c_return: cover property (o_core_cmd.pop);
	c_wake: cover property (o_wake);
endmodule : irqc_top_chk

bind irqc_top irqc_top_chk #(.N_PERIPH(N_PERIPH), .Q_DIV(Q_DIV)) u_chk (.i_clock, .i_rst_n,
	.i_reg_addr, .i_reg_rd, .o_reg_rdata, .i_core_sleeping, .i_core_pc, .i_core_ctx, .o_q1,
	.o_wake, .o_core_cmd, .o_push_pc, .o_vector_pc, .o_restore_ctx, .o_irq_pending);

// ---- irqc_core_model.sv ----
// behavioural core: stack, program counter, live context and sleep
`timescale 1ns/10ps
module irqc_core_model
	import irqc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_q1,
	input wire logic i_wake,
	input wire irqc_core_cmd_s i_cmd,
	input wire logic [14:0] i_push_pc,
	input wire logic [14:0] i_vector_pc,
	input wire irqc_ctx_s i_restore_ctx,
	input wire irqc_ctx_s i_set_ctx, // context written by software
	input wire logic i_set,
	input wire logic i_sleep, // execute a sleep
	input wire logic i_ret_req, // execute a return
	output logic [14:0] o_pc,
	output irqc_ctx_s o_ctx,
	output logic o_sleeping,
	output logic o_ret,
	output int o_nops,
	output int o_entries
);
	logic [14:0] stack_q [$]; // hardware stack
	// pipeline steps once per instruction cycle
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pc <= 15'h0100;
			o_ctx <= '0;
			o_sleeping <= 1'b0;
			o_ret <= 1'b0;
			o_nops <= 0;
			o_entries <= 0;
		end else begin
			if (i_set) begin
				o_ctx <= i_set_ctx;
			end else if (i_q1 && i_cmd.restore) begin
				o_ctx <= i_restore_ctx;
			end
			if (i_sleep) begin
				o_sleeping <= 1'b1;
			end else if (i_wake) begin
				o_sleeping <= 1'b0;
			end
			// return held until a cycle start samples it
			if (i_ret_req) begin
				o_ret <= 1'b1;
			end else if (i_q1) begin
				o_ret <= 1'b0;
			end
			if (i_q1 && i_cmd.force_nop) begin
				o_nops <= o_nops + 1;
			end
			if (i_q1 && i_cmd.load_vector) begin
				stack_q.push_back(i_push_pc);
				o_pc <= i_vector_pc;
				o_entries <= o_entries + 1;
			end else if (i_q1 && i_cmd.pop) begin
				o_pc <= stack_q.pop_back();
			end else if (i_q1 && !i_cmd.force_nop && !o_sleeping) begin
				o_pc <= o_pc + 15'h0001;
			end
		end
	end
endmodule : irqc_core_model

// ---- irqc_top_test.sv ----
// self-checking bench for the interrupt controller with a core model
`timescale 1ns/10ps
module irqc_top_test;
	import irqc_pkg::*;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [7:0] i_reg_wdata = 8'h00;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic i_ext_pin = 1'b0;
	logic [7:0] i_periph_event = 8'h00;
	logic [7:0] o_reg_rdata, v;
	logic i_core_sleeping, i_return_from_handler, o_q1, o_wake, o_irq_pending;
	logic [14:0] i_core_pc, o_push_pc, o_vector_pc;
	irqc_ctx_s i_core_ctx, o_restore_ctx, ctx0, ctx_e;
	irqc_ctx_s ctx_set = '0; // context loaded into the core
	irqc_core_cmd_s o_core_cmd;
	logic ctx_load = 1'b0;
	logic go_sleep = 1'b0;
	logic ret_req = 1'b0;
	logic rd_seen = 1'b0; // a read was issued last cycle
	logic [31:0] rng = 32'h0000_2B1C;
	logic [7:0] exp_q [$]; // expected read data, oldest first
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int m_nops, m_entries;

	always #10 i_clock = ~i_clock;

	irqc_top #(.N_PERIPH(8), .Q_DIV(4)) DUT (.i_clock, .i_rst_n, .i_reg_addr, .i_reg_wdata,
		.i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_ext_pin, .i_periph_event, .i_core_sleeping,
		.i_return_from_handler, .i_core_pc, .i_core_ctx, .o_q1, .o_wake, .o_core_cmd,
		.o_push_pc, .o_vector_pc, .o_restore_ctx, .o_irq_pending);
	irqc_core_model u_core (.i_clock, .i_rst_n, .i_q1(o_q1), .i_wake(o_wake),
		.i_cmd(o_core_cmd), .i_push_pc(o_push_pc), .i_vector_pc(o_vector_pc),
		.i_restore_ctx(o_restore_ctx), .i_set_ctx(ctx_set), .i_set(ctx_load),
		.i_sleep(go_sleep), .i_ret_req(ret_req), .o_pc(i_core_pc), .o_ctx(i_core_ctx),
		.o_sleeping(i_core_sleeping), .o_ret(i_return_from_handler), .o_nops(m_nops),
		.o_entries(m_entries));

	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : rnd

	task automatic cmp_core(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp_core

	task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
		cmp_core({56'h0, g}, {56'h0, e});
	endtask : cmp_rd

	task end_sim;
		$display("counts: tests=%0d errors=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	// read data is compared with the oldest note
	always @(posedge i_clock) begin
		if (rd_seen) begin
			cmp_rd(o_reg_rdata, exp_q.pop_front());
		end
		rd_seen <= i_reg_rd;
	end

	// hang guard
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			num_errors++;
			end_sim();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
	endtask : tick

	task automatic wait_q(input int n);
		repeat (n) begin
			@(posedge i_clock);
			while (o_q1 !== 1'b1)
				@(posedge i_clock);
		end
	endtask : wait_q

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clock);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		exp_q.push_back(e);
		@(posedge i_clock);
		i_reg_rd <= 1'b0;
	endtask : rd

	task automatic pin(input logic p);
		@(posedge i_clock);
		i_ext_pin <= p;
		tick(3);
	endtask : pin

	task automatic pulse(input logic [7:0] e);
		@(posedge i_clock);
		i_periph_event <= e;
		@(posedge i_clock);
		i_periph_event <= 8'h00;
		tick(2);
	endtask : pulse

	task automatic setc(input irqc_ctx_s c);
		@(posedge i_clock);
		ctx_set <= c;
		ctx_load <= 1'b1;
		@(posedge i_clock);
		ctx_load <= 1'b0;
	endtask : setc

	task automatic to_sleep();
		@(posedge i_clock);
		go_sleep <= 1'b1;
		@(posedge i_clock);
		go_sleep <= 1'b0;
	endtask : to_sleep

	// main sequence
	initial begin
		tick(20);
		i_rst_n <= 1'b1;
		rd(8'h00, 8'h01);
		rd(8'h05, 8'h01);
		rd(8'hE0, 8'h00);
		wr(8'h00, 8'hBF);
		rd(8'h00, 8'h81);
		wr(8'h00, 8'h40);
		rd(8'h00, 8'h40);
		$display("test registers done");
		pin(1'b1);
		rd(8'h02, 8'h00);
		pin(1'b0);
		rd(8'h02, 8'h01);
		wr(8'h02, 8'h00);
		wr(8'h00, 8'h01);
		pin(1'b1);
		rd(8'h02, 8'h01);
		wr(8'h02, 8'h00);
		v = 8'(rnd());
		pulse(v);
		rd(8'h04, v);
		wr(8'h04, 8'h00);
		$display("test flags done");
		ctx0 = {rnd(), rnd()};
		setc(ctx0);
		wr(8'h01, 8'h01);
		pin(1'b0);
		wr(8'h00, 8'h81);
		pin(1'b1);
		while (m_entries < 1)
			@(posedge i_clock);
		cmp_core(64'(i_core_pc), 64'h4);
		wait_q(3);
		cmp_core(64'(m_nops), 64'h2);
		rd(8'h00, 8'h01);
		rd(8'hF9, ctx0.status & 8'hE7);
		rd(8'hFF, ctx0.pc_upper_latch);
		setc(~ctx0);
		wr(8'hF8, 8'h5A);
		wr(8'h02, 8'h00);
		ctx_e = ctx0;
		ctx_e.status = ctx0.status & 8'hE7;
		ctx_e.wreg = 8'h5A;
		@(posedge i_clock);
		ret_req <= 1'b1;
		@(posedge i_clock);
		ret_req <= 1'b0;
		wait_q(2);
		cmp_core(i_core_ctx, ctx_e);
		rd(8'h00, 8'h81);
		$display("test entry done");
		wr(8'h00, 8'h40);
		wr(8'h03, 8'h01);
		to_sleep();
		pulse(8'h02);
		cmp_core(64'(i_core_sleeping), 64'h1);
		pulse(8'h01);
		cmp_core(64'(i_core_sleeping), 64'h0);
		wait_q(4);
		cmp_core(64'(m_entries), 64'h1);
		wr(8'h04, 8'h00);
		wr(8'h00, 8'hC0);
		to_sleep();
		pulse(8'h01);
		while (m_entries < 2)
			@(posedge i_clock);
		cmp_core(64'(i_core_pc), 64'h4);
		$display("test sleep done");
		end_sim();
	end
endmodule : irqc_top_test
